// File: tce_pkg.sv
// Constants for the cascaded 16-bit timer and event counter
package tce_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_MODE = 4'h1;
    localparam logic [3:0] ADDR_MATCH_LO = 4'h2;
    localparam logic [3:0] ADDR_MATCH_HI = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_MASK = 4'h5;
    localparam logic [3:0] ADDR_COUNT_LO = 4'h6;
    localparam logic [3:0] ADDR_COUNT_HI = 4'h7;
    // Control register fields
    localparam int CTRL_LOWER_RUN = 0;
    localparam int CTRL_UPPER_RUN = 1;
    localparam int CTRL_CASCADE = 2;
    // Mode register fields
    localparam int MODE_CLK_LSB = 0;
    localparam int MODE_EXT = 3;
    localparam int MODE_CM_LSB = 4;
    localparam int MODE_DBE = 6;
    // Status and mask fields
    localparam int ST_MATCH = 0;
    localparam int ST_WRAP = 1;
    localparam int ST_W = 2;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [15:0] MATCH_RST = 16'hFFFF;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [1:0] STATUS_RST = 2'h0;
    // Prescaler widths in bits
    localparam int PRE_W = 11;
    localparam int LS_PRE_W = 4;
    // Divider exponent that marks a clock select code with no tick
    localparam logic [3:0] NO_TICK = 4'hF;
    typedef enum logic [1:0] {
        TCE_CM_TIMER0 = 2'b00,
        TCE_CM_TIMER1 = 2'b01,
        TCE_CM_PWM = 2'b10,
        TCE_CM_RSVD = 2'b11
    } tce_cm_t;
endpackage

// File: tce_timer16.sv
// Cascaded 16-bit interval timer and event counter with register port
`timescale 1ns/10ps
// Summary of operation
// - Buffer enable bit turns buffering off/on
// - Buffered running write lands in buffer and readback, not active
// - On match, raise interrupt, load buffered value
// - Stopped write updates buffer and active together
// - Unbuffered running write applies at once
// - Unbuffered equal value written matches immediately
// - Match readback returns last written value
// - Low byte first; high write commits both
// - Cascade bit chains channels; upper mode rules
// - Mode 00/01 counts; external bit selects events
// - Event mode counts pin falling edges
// - Match raises interrupt, clears counter, resumes
// - Clearing upper run stops and clears counter
// - Mode writes ignored while any run set
// - Clock select picks fixed divider per power mode
// - Interval mode counts selected internal ticks
// - Interval mode needs external bit clear
module tce_timer16
    import tce_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    output logic [7:0] rd_data_out,
    input wire logic event_pin_in,
    input wire logic low_speed_clock_in,
    input wire logic slow_mode_in,
    output logic match_irq_out,
    output logic [15:0] count_out
);
    logic [7:0] ctrl_ff;
    logic [7:0] mode_ff;
    logic [7:0] match_low_byte_ff;
    logic [15:0] match_value_16_ff;
    logic [15:0] buffer_ff;
    logic [15:0] active_ff;
    logic [15:0] count_ff;
    logic [ST_W-1:0] status_ff;
    logic [ST_W-1:0] mask_ff;
    logic [7:0] rd_data_ff;
    logic [PRE_W-1:0] pre_ff;
    logic [LS_PRE_W-1:0] ls_pre_ff;
    logic [2:0] ev_sync_ff;
    logic [2:0] ls_sync_ff;
    logic [1:0] slow_sync_ff;

    // Divider exponent for each clock select code and power mode
    function automatic logic [3:0] div_exp(input logic [2:0] sel,
                                           input logic slow);
        logic [3:0] e;
        e = NO_TICK;
        if (!slow) begin
            case (sel)
                3'h0: e = 4'hB;
                3'h1: e = 4'hA;
                3'h2: e = 4'h8;
                3'h3: e = 4'h6;
                3'h4: e = 4'h4;
                3'h5: e = 4'h2;
                3'h6: e = 4'h1;
                default: e = 4'h0;
            endcase
        end else begin
            case (sel)
                3'h0: e = 4'h4;
                3'h1: e = 4'h3;
                3'h7: e = 4'h2;
                default: e = NO_TICK;
            endcase
        end
        return e;
    endfunction

    // True when the low e bits of a prescaler are all ones
    function automatic logic ones_low(input logic [PRE_W-1:0] v,
                                      input logic [3:0] e);
        logic [PRE_W-1:0] m;
        m = PRE_W'((12'h001 << e) - 12'h001);
        return (v & m) == m;
    endfunction

    wire slow_w = slow_sync_ff[1];
    wire ls_rise_w = ls_sync_ff[1] & ~ls_sync_ff[2];
    wire ev_fall_w = ~ev_sync_ff[1] & ev_sync_ff[2];
    wire [3:0] exp_w = div_exp(mode_ff[MODE_CLK_LSB +: 3], slow_w);
    wire upper_run_w = ctrl_ff[CTRL_UPPER_RUN];
    wire any_run_w = upper_run_w | ctrl_ff[CTRL_LOWER_RUN];
    wire buf_en_w = mode_ff[MODE_DBE];
    wire ext_sel_w = mode_ff[MODE_EXT];
    wire [1:0] cm_w = mode_ff[MODE_CM_LSB +: 2];
    // Only the upper channel's mode matters once chained
    wire cnt_mode_w = ctrl_ff[CTRL_CASCADE] &&
        (cm_w == TCE_CM_TIMER0 || cm_w == TCE_CM_TIMER1);
    wire active_run_w = upper_run_w & cnt_mode_w;
    // Internal tick from the system or low-speed divider
    wire int_tick_w = (exp_w != NO_TICK) && (slow_w ?
        ls_rise_w && ones_low(PRE_W'(ls_pre_ff), exp_w) :
        ones_low(pre_ff, exp_w));
    wire tick_w = ext_sel_w ? ev_fall_w : int_tick_w;
    // Compared every cycle so an equal write matches at once
    wire match_w = active_run_w && count_ff == active_ff;
    wire wrap_w = active_run_w && !match_w && tick_w &&
        count_ff == 16'hFFFF;

    wire wr_ctrl_w = wr_en_in && addr_in == ADDR_CTRL;
    wire wr_mode_w = wr_en_in && addr_in == ADDR_MODE && !any_run_w;
    wire wr_lo_w = wr_en_in && addr_in == ADDR_MATCH_LO;
    wire wr_hi_w = wr_en_in && addr_in == ADDR_MATCH_HI;
    wire wr_st_w = wr_en_in && addr_in == ADDR_STATUS;
    wire wr_mask_w = wr_en_in && addr_in == ADDR_MASK;
    wire [15:0] new_match_w = {wr_data_in, match_low_byte_ff};
    // Stopped or unbuffered commits go straight to the comparator
    wire direct_w = !upper_run_w || !buf_en_w;

    logic [15:0] nxt_count;
    logic [15:0] nxt_active;
    logic [ST_W-1:0] nxt_status;
    logic [7:0] nxt_rd_data;
    logic [ST_W-1:0] ev_set;

    assign ev_set = {wrap_w, match_w};

    always_comb begin
        nxt_count = count_ff;
        if (!upper_run_w) begin
            nxt_count = COUNT_RST;
        end else if (match_w) begin
            nxt_count = COUNT_RST;
        end else if (active_run_w && tick_w) begin
            nxt_count = 16'(count_ff + 16'h0001);
        end
    end

    always_comb begin
        nxt_active = active_ff;
        if (wr_hi_w && direct_w) begin
            nxt_active = new_match_w;
        end else if (match_w && buf_en_w) begin
            nxt_active = buffer_ff;
        end
    end

    // Hardware set wins over a write-one clear in the same cycle
    assign nxt_status = (status_ff & ~(wr_st_w ? wr_data_in[ST_W-1:0] :
        {ST_W{1'b0}})) | ev_set;

    always_comb begin
        nxt_rd_data = 8'h00;
        case (addr_in)
            ADDR_CTRL: nxt_rd_data = ctrl_ff;
            ADDR_MODE: nxt_rd_data = mode_ff;
            ADDR_MATCH_LO: nxt_rd_data = match_value_16_ff[7:0];
            ADDR_MATCH_HI: nxt_rd_data = match_value_16_ff[15:8];
            ADDR_STATUS: nxt_rd_data = 8'(status_ff);
            ADDR_MASK: nxt_rd_data = 8'(mask_ff);
            ADDR_COUNT_LO: nxt_rd_data = count_ff[7:0];
            ADDR_COUNT_HI: nxt_rd_data = count_ff[15:8];
            default: nxt_rd_data = 8'h00;
        endcase
        if (!rd_en_in) begin
            nxt_rd_data = 8'h00;
        end
    end

    // Pin and low-speed clock pass two flops before any use
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ev_sync_ff <= 3'h7;
            ls_sync_ff <= 3'h0;
            slow_sync_ff <= 2'h0;
        end else begin
            ev_sync_ff <= {ev_sync_ff[1:0], event_pin_in};
            ls_sync_ff <= {ls_sync_ff[1:0], low_speed_clock_in};
            slow_sync_ff <= {slow_sync_ff[0], slow_mode_in};
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pre_ff <= '0;
            ls_pre_ff <= '0;
        end else begin
            pre_ff <= PRE_W'(pre_ff + 1'b1);
            if (ls_rise_w) begin
                ls_pre_ff <= LS_PRE_W'(ls_pre_ff + 1'b1);
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ctrl_ff <= CTRL_RST;
            mode_ff <= MODE_RST;
            mask_ff <= '0;
        end else begin
            if (wr_ctrl_w) begin
                ctrl_ff <= wr_data_in & 8'h07;
            end
            if (wr_mode_w) begin
                mode_ff <= wr_data_in & 8'h7F;
            end
            if (wr_mask_w) begin
                mask_ff <= wr_data_in[ST_W-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            match_low_byte_ff <= MATCH_RST[7:0];
            match_value_16_ff <= MATCH_RST;
            buffer_ff <= MATCH_RST;
            active_ff <= MATCH_RST;
        end else begin
            if (wr_lo_w) begin
                match_low_byte_ff <= wr_data_in;
            end
            if (wr_hi_w) begin
                match_value_16_ff <= new_match_w;
                buffer_ff <= new_match_w;
            end
            active_ff <= nxt_active;
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            count_ff <= COUNT_RST;
            status_ff <= STATUS_RST;
            rd_data_ff <= 8'h00;
        end else begin
            count_ff <= nxt_count;
            status_ff <= nxt_status;
            rd_data_ff <= nxt_rd_data;
        end
    end

    assign rd_data_out = rd_data_ff;
    assign count_out = count_ff;
    assign match_irq_out = |(status_ff & mask_ff);

    sequence s_hi_write_running_buffered;
        wr_hi_w && upper_run_w && buf_en_w;
    endsequence

    sequence s_match_cleared;
        count_ff == 16'h0000;
    endsequence

    buffer_hold_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        s_hi_write_running_buffered and !match_w |=>
        active_ff == $past(active_ff))
        else $error("buffered write reached the comparator");

    buffer_load_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        match_w && buf_en_w && !wr_hi_w |=>
        active_ff == $past(buffer_ff) && status_ff[ST_MATCH])
        else $error("match did not load buffer or flag");

    stopped_write_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        wr_hi_w && !upper_run_w |=>
        active_ff == buffer_ff && active_ff == match_value_16_ff)
        else $error("stopped write not applied to both");

    direct_write_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        wr_hi_w && !buf_en_w |=> active_ff == $past(new_match_w))
        else $error("unbuffered write not applied");

    equal_match_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        wr_hi_w && !buf_en_w && active_run_w &&
        new_match_w == count_ff && !tick_w && !match_w
        |=> match_w ##1 s_match_cleared)
        else $error("equal write did not match at once");

    readback_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        rd_en_in && addr_in == ADDR_MATCH_HI |=>
        rd_data_out == $past(match_value_16_ff[15:8]))
        else $error("match readback wrong");

    match_clear_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        match_w && upper_run_w |=> s_match_cleared and
        status_ff[ST_MATCH])
        else $error("match did not clear counter");

    stop_clear_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        $fell(upper_run_w) |=> s_match_cleared)
        else $error("stop did not clear counter");

    stop_hold_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        !upper_run_w && !$past(upper_run_w) |-> s_match_cleared)
        else $error("stopped counter not held at zero");

    mode_lock_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        any_run_w |=> mode_ff == $past(mode_ff))
        else $error("mode changed while running");

    event_count_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        active_run_w && ext_sel_w && !ev_fall_w && !match_w
        && !wr_ctrl_w |=> count_ff == $past(count_ff))
        else $error("count moved without event edge");

    wrap_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        wrap_w && !wr_ctrl_w |=> count_ff == 16'h0000 &&
        status_ff[ST_WRAP])
        else $error("counter did not wrap");

    mode_gate_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        upper_run_w && !cnt_mode_w |=> count_ff == $past(count_ff))
        else $error("count moved outside a counting mode");

    low_only_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        wr_lo_w && !match_w |=> active_ff == $past(active_ff))
        else $error("low byte alone reached the comparator");

    value_hold_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        !wr_hi_w |=> match_value_16_ff == $past(match_value_16_ff))
        else $error("readback value changed without a write");

    irq_raise_a: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        match_w && mask_ff[ST_MATCH] && !wr_mask_w |=> match_irq_out)
        else $error("unmasked match did not raise interrupt");

endmodule // tce_timer16

// File: tce_event_src.sv
// Behavioural event pulse source for the counter input pin
`timescale 1ns/10ps
module tce_event_src (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic req_in,
    input wire logic [2:0] width_in,
    output logic pin_out,
    output logic busy_out
);
    logic [3:0] cnt_ff;
    logic [3:0] half_ff;
    assign busy_out = (cnt_ff != 4'h0);
    // Pin idles high like a pulled-up input; each level lasts about
    // width_in cycles, and the bench never asks for less than 2
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt_ff <= 4'h0;
            half_ff <= 4'h0;
            pin_out <= 1'b1;
        end else if (req_in && !busy_out) begin
            cnt_ff <= {width_in, 1'b0};
            half_ff <= {1'b0, width_in};
            pin_out <= 1'b0;
        end else if (busy_out) begin
            cnt_ff <= cnt_ff - 4'h1;
            pin_out <= ((cnt_ff - 4'h1) <= half_ff);
        end
    end
endmodule // tce_event_src

// File: tb_cascaded_16bit_timer_event_counter.sv
// Self-checking bench for the cascaded 16-bit timer and event counter
`timescale 1ns/10ps
module tb_cascaded_16bit_timer_event_counter;
    import tce_pkg::*;
    logic clk, rst, wr_en, rd_en, ev_req, pin, ev_busy, irq, slow;
    logic [2:0] ls_div = 3'h0;
    wire ls_clk = ls_div[2];
    logic [3:0] addr;
    logic [7:0] wdata, rdata, rv;
    logic [2:0] ev_w;
    logic [15:0] count, c0;
    int errors = 0, checks_done = 0, cyc = 0;
    int m_cnt = 0, m_act = 0, m_last = 0, m_st = 0;
    int m_dbe = 0, m_run = 0, m_mask = 0;
    int ex[8] = '{11, 10, 8, 6, 4, 2, 1, 0};

    tce_timer16 dut_u (.ref_clk_in(clk), .sys_rst_in(rst), .addr_in(addr),
        .wr_data_in(wdata), .wr_en_in(wr_en), .rd_en_in(rd_en),
        .rd_data_out(rdata), .event_pin_in(pin), .low_speed_clock_in(ls_clk),
        .slow_mode_in(slow), .match_irq_out(irq), .count_out(count));
    tce_event_src src_u (.ref_clk_in(clk), .sys_rst_in(rst),
        .req_in(ev_req), .width_in(ev_w), .pin_out(pin), .busy_out(ev_busy));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Stand-in low-speed clock, one rise every 8 system clocks
    always @(posedge clk) begin
        ls_div <= ls_div + 3'h1;
    end

    task automatic conclude;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 95000) begin
            errors++;
            conclude;
        end
    end

    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rchk(input string what, input logic [3:0] a,
                        input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 chk(what, {8'h00, rdata}, {8'h00, e});
    endtask

    // Model of a low-then-high match write; the high byte commits both
    task automatic wm(input int v);
        wr(ADDR_MATCH_LO, v[7:0]);
        wr(ADDR_MATCH_HI, v[15:8]);
        m_last = v;
        if (!m_run || !m_dbe) m_act = v;
        if (m_run && !m_dbe && v == m_cnt) begin
            m_cnt = 0;
            m_st |= 1;
        end
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic ev(input int n);
        repeat (n) begin
            @(posedge clk);
            ev_req <= 1'b1;
            ev_w <= 3'($urandom_range(5, 2));
            @(posedge clk);
            ev_req <= 1'b0;
            repeat (16) @(posedge clk);
            if (m_run) m_cnt++;
            if (m_run && m_cnt == m_act) begin
                m_cnt = 0;
                m_st |= 1;
                if (m_dbe) m_act = m_last;
            end
            #1 chk("count", count, 16'(m_cnt));
            chk("irq", {15'h0, irq}, 16'((m_st & m_mask) != 0));
        end
    endtask

    task automatic clear_status;
        wr(ADDR_STATUS, 8'h03);
        m_st = 0;
        @(posedge clk);
        #1 chk("irq", {15'h0, irq}, 16'h0);
    endtask

    initial begin
        rst = 1'b1;
        addr = 4'h0;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        ev_req = 1'b0;
        ev_w = 3'h2;
        slow = 1'b0;
        void'($urandom(49));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 9; a++) begin
            rchk("reset", 4'(a), (a == 2 || a == 3) ? 8'hFF : 8'h00);
        end
        wr(ADDR_MASK, 8'h01);
        m_mask = 1;
        wr(ADDR_MODE, 8'h08);
        wm(3);
        // Upper run alone must not count without the cascade bit
        wr(ADDR_CTRL, 8'h02);
        ev(1);
        wr(ADDR_CTRL, 8'h06);
        m_run = 1;
        wr(ADDR_MODE, 8'h00);
        rchk("mode", ADDR_MODE, 8'h08);
        ev(3);
        rchk("status", ADDR_STATUS, 8'h01);
        clear_status();
        ev(2);
        wm(2);
        chk("count", count, 16'(m_cnt));
        rchk("status", ADDR_STATUS, 8'h01);
        clear_status();
        ev(1);
        wr(ADDR_CTRL, 8'h04);
        m_run = 0;
        m_cnt = 0;
        @(posedge clk);
        #1 chk("count", count, 16'h0000);
        wr(ADDR_MODE, 8'h48);
        m_dbe = 1;
        wr(ADDR_CTRL, 8'h06);
        m_run = 1;
        wm(5);
        rchk("match lo", ADDR_MATCH_LO, 8'h05);
        rchk("match hi", ADDR_MATCH_HI, 8'h00);
        ev(3);
        ev(5);
        wr(ADDR_MASK, 8'h00);
        @(posedge clk);
        #1 chk("irq", {15'h0, irq}, 16'h0);
        wr(ADDR_MASK, 8'h01);
        @(posedge clk);
        #1 chk("irq", {15'h0, irq}, 16'h1);
        wr(ADDR_CTRL, 8'h04);
        m_run = 0;
        m_dbe = 0;
        wm(65535);
        // Mode field 10 is not a counting mode even with a fast clock
        wr(ADDR_MODE, 8'h27);
        wr(ADDR_CTRL, 8'h06);
        repeat (16) @(posedge clk);
        #1 chk("pwm code", count, 16'h0000);
        // Lower run alone must lock the mode register as well
        wr(ADDR_CTRL, 8'h01);
        wr(ADDR_MODE, 8'h07);
        rchk("mode", ADDR_MODE, 8'h27);
        slow <= 1'b1;
        // Slow codes 000, 001, 111 divide by 16, 8, 4; 010 never ticks
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_CTRL, 8'h04);
            wr(ADDR_MODE, (k == 3) ? 8'h02 : (k == 2) ? 8'h07 : 8'(k));
            wr(ADDR_CTRL, 8'h06);
            @(posedge clk);
            #1 c0 = count;
            repeat ((k == 3) ? 64 : (32 << (4 - k))) @(posedge clk);
            #1 chk("slow ticks", count - c0,
                (k == 3) ? 16'h0000 : 16'h0004);
        end
        slow <= 1'b0;
        // Each select code must give exactly 4 ticks in 4 divider periods
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_CTRL, 8'h04);
            wr(ADDR_MODE, 8'(c + (c % 2) * 16));
            wr(ADDR_CTRL, 8'h06);
            @(posedge clk);
            #1 c0 = count;
            repeat (4 << ex[c]) @(posedge clk);
            #1 chk("ticks", count - c0, 16'h0004);
        end
        wr(ADDR_CTRL, 8'h04);
        clear_status();
        wm(16'h8000);
        wr(ADDR_CTRL, 8'h06);
        m_run = 1;
        repeat (16'h1000) @(posedge clk);
        wm(16'h0010);
        rchk("status", ADDR_STATUS, 8'h00);
        for (int i = 0; i < 70000 && count !== 16'h0000; i++) begin
            @(posedge clk);
            #1;
        end
        chk("wrapped", count, 16'h0000);
        repeat (48) @(posedge clk);
        rchk("status", ADDR_STATUS, 8'h03);
        conclude;
    end
endmodule // tb_cascaded_16bit_timer_event_counter
